// ===== hw/dpc_pkg.sv
// Purpose: Shared constants and types for the core and PCM clock control, plus
//          the glitch-free core clock gate.
// Assumes: Single 100 MHz mclk domain; foreign levels are synchronised first.
// Notes:   The gate only follows its enable while the source level is low.
package dpc_pkg;
    localparam int MCLK_KHZ      = 100000;
    localparam int CLKOUT_KHZ    = 25000;
    localparam int CLKOUT_HALF   = MCLK_KHZ / (2 * CLKOUT_KHZ);
    localparam int PCM_INT_KHZ   = 2083;
    localparam int PCM_INT_HALF  = MCLK_KHZ / (2 * PCM_INT_KHZ);
    localparam int SETTLE_MS     = 4;
    localparam int SETTLE_CYCLES = SETTLE_MS * MCLK_KHZ;
    localparam logic [1:0] CAP_WAIT       = 2'h2;
    localparam logic [3:0] TEST_PCM_EXT   = 4'h3;
    localparam logic [3:0] TEST_TIC       = 4'h5;
    localparam logic [15:0] NCO_STEP_1536 = 16'h3000;
    localparam logic [15:0] NCO_STEP_2048 = 16'h4000;
    localparam logic [15:0] NCO_STEP_4096 = 16'h8000;
    localparam logic [9:0] FRAME_LAST_24  = 10'h0bf;
    localparam logic [9:0] FRAME_LAST_32  = 10'h0ff;
    localparam logic [9:0] FRAME_LAST_64  = 10'h1ff;
    localparam logic [9:0] FRAME_LAST_128 = 10'h3ff;

    typedef enum logic [1:0] {
        DPC_F100 = 2'h0,
        DPC_F180 = 2'h1,
        DPC_F190 = 2'h2,
        DPC_F200 = 2'h3
    } dpc_freq_e;

    typedef enum logic [1:0] {
        DPC_R1536 = 2'h0,
        DPC_R2048 = 2'h1,
        DPC_R4096 = 2'h2,
        DPC_R8192 = 2'h3
    } dpc_rate_e;

    typedef enum logic [1:0] {
        DPC_BT_WAIT = 2'h0,
        DPC_BT_CAPT = 2'h1,
        DPC_BT_BOOT = 2'h3,
        DPC_BT_RUN  = 2'h2
    } dpc_boot_e;

    typedef struct packed {
        logic      core_en;
        dpc_freq_e core_freq;
        dpc_rate_e pcm_rate;
        logic      pdc_out;
        logic      pfs_out;
    } dpc_cfg_s;

    localparam dpc_cfg_s CFG_RST = '{core_en: 1'b1, core_freq: DPC_F100,
                                     pcm_rate: DPC_R1536, pdc_out: 1'b0, pfs_out: 1'b0};

    typedef struct packed {
        logic [3:0] test_sel;
        logic       boot;
        logic       iface;
        logic       width;
        logic       arm_freq;
        logic       bypass;
        logic       xtal;
        logic       pxtal;
        logic       dsp_src;
        logic       pdc_in;
        logic       pfs_in;
    } dpc_pins_s;

    typedef struct packed {
        logic boot_int;
        logic hpi;
        logic width16;
        logic arm_fast;
        logic bypass;
        logic pcm_ext;
        logic tic;
    } dpc_strap_s;

    typedef struct packed {
        logic run;
    } dpc_gate_s;
endpackage

`timescale 1ns/1ns
module dpc_clk_gate (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Source level and request
    input  wire logic src_lvl,
    input  wire logic enable,
    // Gate
    output logic      gate_en
);
    dpc_pkg::dpc_gate_s st;
    dpc_pkg::dpc_gate_s next_st;

    always_comb begin
        next_st = st;
        // Moving only in the low phase avoids a clipped high pulse
        if (!src_lvl) begin
            next_st.run = enable;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st.run <= dpc_pkg::CFG_RST.core_en;
        end else begin
            st <= next_st;
        end
    end

    assign gate_en = st.run;

    chk_gate_low_phase: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(st.run) |-> !$past(src_lvl))
        else $error("core gate moved during high source phase");
endmodule

// ===== hw/dpc_clock_ctrl.sv
// Purpose: Core clock gating and selection, PCM clock and frame sync, master
//          clock out, and reset-time strap handling for the boot memory pins.
// Assumes: Control bits come from logic on mclk; all pins pass two flops first.
// Notes:   Generated clocks are mclk-sampled levels, good for pins only.
// Behaviour
// - Core clock chooses one of four frequencies through a select field.
// - Internal PCM clock of 2083 kHz is divided from the reference.
// - Test select 0011 takes PCM clock from the external PCM crystal.
// - PCM bit clock from the external crystal selectable as 1536, 2048, 4096 or 8192 kHz; internal stays at 2083 kHz.
// - PCM data clock and frame sync each selectable as input or output.
// - Control-processor PLL frequency follows the frequency-select strap.
// - Bypass uses crystal for core, test input for CPU, PCM crystal for PCM.
// - A 25 MHz copy of the reference drives the clock output pin.
// - Active-low master reset acts asynchronously.
// - Boot strap 1 selects internal ROM, 0 external; test mode makes request A while the boot pin is high.
// - Interface strap 1 routes shared pins to host port, 0 to GPIO/keypad.
// - Memory address outputs are zero at power-up and after reset.
// - Memory output enable asserts after reset when external boot is chosen.
// - External boot asserts chip select zero only during fetch, else holds it high; the other selects follow address decode.
// - Boot memory on chip select zero is 8 bits with width strap low, else 16.
`timescale 1ns/1ns
module dpc_clock_ctrl #(
    parameter int SETTLE_CYCLES = dpc_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Control bits
    input  wire logic             cfg_wr,
    input  wire dpc_pkg::dpc_cfg_s cfg_wdata,
    output dpc_pkg::dpc_cfg_s     cfg_rdata,
    output logic                  dsp_pll_settled,
    // Pins
    input  wire dpc_pkg::dpc_pins_s pins,
    // Clock outputs
    output dpc_pkg::dpc_freq_e    dsp_freq_sel,
    output logic                  dsp_gate_en,
    output logic                  dsp_src_xtal,
    output logic                  arm_pll_fast,
    output logic                  arm_clk_test,
    output logic                  clk_out,
    // PCM pins
    output logic                  pdc_o,
    output logic                  pdc_oe,
    output logic                  pfs_o,
    output logic                  pfs_oe,
    // Strap results
    output logic                  boot_internal,
    output logic                  hpi_route,
    output logic                  cs0_width16,
    output logic                  tic_req_a,
    // Boot memory pins
    input  wire logic [21:0]      mem_addr_req,
    input  wire logic             mem_oe_req_n,
    input  wire logic             fetch,
    input  wire logic [2:0]       cs_dec_n,
    input  wire logic             remap,
    output logic [21:0]           mem_addr,
    output logic                  mem_oe_n,
    output logic [2:0]            esm_cs_n
);
    typedef struct packed {
        dpc_pkg::dpc_pins_s  s1;
        dpc_pkg::dpc_pins_s  s2;
        dpc_pkg::dpc_boot_e  boot;
        logic [1:0]          cap_cnt;
        dpc_pkg::dpc_strap_s strap;
        dpc_pkg::dpc_cfg_s   cfg;
        logic [18:0]         settle;
        logic                settled;
        logic [1:0]          ck_cnt;
        logic                ck;
        logic [4:0]          pcm_div;
        logic                pcm_int;
        logic                pxtal_q;
        logic [15:0]         nco;
        logic                pdc;
        logic                bclk_q;
        logic [9:0]          bit_cnt;
        logic                pfs;
        logic [21:0]         addr;
        logic                oe_n;
        logic [2:0]          cs_n;
        logic                treq;
    } dpc_top_s;

    dpc_top_s   st;
    dpc_top_s   next_st;
    logic       gate_src;
    logic       bclk;
    logic [15:0] nco_step;
    logic [9:0] frame_last;
    logic       ext_boot;

    // Core clock source; in bypass the crystal feeds the core directly
    assign gate_src = st.strap.bypass ? st.s2.xtal : st.s2.dsp_src;
    // Framing follows whichever clock is on the pin
    assign bclk     = st.cfg.pdc_out ? st.pdc : st.s2.pdc_in;
    assign ext_boot = !st.strap.boot_int;

    always_comb begin
        case (st.cfg.pcm_rate)
            dpc_pkg::DPC_R1536: begin
                nco_step   = dpc_pkg::NCO_STEP_1536;
                frame_last = dpc_pkg::FRAME_LAST_24;
            end
            dpc_pkg::DPC_R2048: begin
                nco_step   = dpc_pkg::NCO_STEP_2048;
                frame_last = dpc_pkg::FRAME_LAST_32;
            end
            dpc_pkg::DPC_R4096: begin
                nco_step   = dpc_pkg::NCO_STEP_4096;
                frame_last = dpc_pkg::FRAME_LAST_64;
            end
            default: begin
                nco_step   = 16'h0000;
                frame_last = dpc_pkg::FRAME_LAST_128;
            end
        endcase
    end

    always_comb begin
        next_st    = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;

        // Straps are caught once the synchronisers hold post-release levels
        case (st.boot)
            dpc_pkg::DPC_BT_WAIT: begin
                next_st.cap_cnt = st.cap_cnt + 2'h1;
                if (st.cap_cnt == dpc_pkg::CAP_WAIT) begin
                    next_st.boot = dpc_pkg::DPC_BT_CAPT;
                end
            end
            dpc_pkg::DPC_BT_CAPT: begin
                next_st.strap.boot_int = st.s2.boot;
                next_st.strap.hpi      = st.s2.iface;
                next_st.strap.width16  = st.s2.width;
                next_st.strap.arm_fast = st.s2.arm_freq;
                next_st.strap.bypass   = st.s2.bypass;
                next_st.strap.pcm_ext  = (st.s2.test_sel == dpc_pkg::TEST_PCM_EXT);
                next_st.strap.tic      = (st.s2.test_sel == dpc_pkg::TEST_TIC);
                next_st.boot           = dpc_pkg::DPC_BT_BOOT;
            end
            dpc_pkg::DPC_BT_BOOT: begin
                if (remap) begin
                    next_st.boot = dpc_pkg::DPC_BT_RUN;
                end
            end
            dpc_pkg::DPC_BT_RUN: begin
                next_st.boot = dpc_pkg::DPC_BT_RUN;
            end
            default: begin
                next_st.boot = dpc_pkg::DPC_BT_WAIT;
            end
        endcase

        // Control bits; a new frequency restarts the settle count
        if (cfg_wr) begin
            next_st.cfg = cfg_wdata;
            if (cfg_wdata.core_freq != st.cfg.core_freq) begin
                next_st.settle  = 19'(SETTLE_CYCLES - 1);
                next_st.settled = 1'b0;
            end
        end else if (st.settle != 19'h0) begin
            next_st.settle = st.settle - 19'h1;
        end else begin
            next_st.settled = 1'b1;
        end

        // Master clock out
        if (st.ck_cnt == 2'(dpc_pkg::CLKOUT_HALF - 1)) begin
            next_st.ck_cnt = 2'h0;
            next_st.ck     = !st.ck;
        end else begin
            next_st.ck_cnt = st.ck_cnt + 2'h1;
        end

        // Internal PCM clock: reference divided, slightly off the 2048 ideal
        if (st.pcm_div == 5'(dpc_pkg::PCM_INT_HALF - 1)) begin
            next_st.pcm_div = 5'h0;
            next_st.pcm_int = !st.pcm_int;
        end else begin
            next_st.pcm_div = st.pcm_div + 5'h1;
        end

        // External crystal path scaled by a phase accumulator per rising crystal edge; 8192 takes the crystal level directly
        next_st.pxtal_q = st.s2.pxtal;
        if (st.s2.pxtal && !st.pxtal_q) begin
            next_st.nco = st.nco + nco_step;
        end
        if (st.strap.pcm_ext || st.strap.bypass) begin
            next_st.pdc = (st.cfg.pcm_rate == dpc_pkg::DPC_R8192) ? st.s2.pxtal
                                                                   : st.nco[15];
        end else begin
            next_st.pdc = st.pcm_int;
        end

        // Frame sync: one bit clock high per frame of 24..128 channels
        next_st.bclk_q = bclk;
        if (bclk && !st.bclk_q) begin
            next_st.bit_cnt = (st.bit_cnt >= frame_last) ? 10'h000 : st.bit_cnt + 10'h001;
            next_st.pfs     = (st.bit_cnt >= frame_last);
        end

        // Boot memory pins
        next_st.treq = st.strap.tic && st.s2.boot;
        if (st.boot == dpc_pkg::DPC_BT_WAIT || st.boot == dpc_pkg::DPC_BT_CAPT) begin
            next_st.addr = 22'h000000;
            next_st.oe_n = 1'b1;
            next_st.cs_n = 3'h7;
        end else if (st.boot == dpc_pkg::DPC_BT_BOOT && ext_boot) begin
            next_st.addr = mem_addr_req;
            next_st.oe_n = 1'b0;
            next_st.cs_n = {cs_dec_n[2:1], !fetch};
        end else begin
            next_st.addr = mem_addr_req;
            next_st.oe_n = mem_oe_req_n;
            next_st.cs_n = cs_dec_n;
        end
    end

    // Asynchronous reset to constants only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.boot    <= dpc_pkg::DPC_BT_WAIT;
            st.cfg     <= dpc_pkg::CFG_RST;
            st.settled <= 1'b1;
            st.oe_n    <= 1'b1;
            st.cs_n    <= 3'h7;
        end else begin
            st <= next_st;
        end
    end

    dpc_clk_gate u_gate (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .src_lvl (gate_src),
        .enable  (st.cfg.core_en),
        .gate_en (dsp_gate_en)
    );

    assign cfg_rdata       = st.cfg;
    assign dsp_pll_settled = st.settled;
    assign dsp_freq_sel    = st.cfg.core_freq;
    assign dsp_src_xtal    = st.strap.bypass;
    assign arm_pll_fast    = st.strap.arm_fast;
    assign arm_clk_test    = st.strap.bypass;
    assign clk_out         = st.ck;
    assign pdc_o           = st.pdc;
    assign pdc_oe          = st.cfg.pdc_out;
    assign pfs_o           = st.pfs;
    assign pfs_oe          = st.cfg.pfs_out;
    assign boot_internal   = st.strap.boot_int;
    assign hpi_route       = st.strap.hpi;
    assign cs0_width16     = st.strap.width16;
    assign tic_req_a       = st.treq;
    assign mem_addr        = st.addr;
    assign mem_oe_n        = st.oe_n;
    assign esm_cs_n        = st.cs_n;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_ck_rise;
        !clk_out ##1 clk_out;
    endsequence

    chk_clkout_period: assert property (s_ck_rise |-> clk_out[*2] ##1 !clk_out[*2] ##1 clk_out)
        else $error("clock output not a quarter of mclk");

    chk_pcm_int_half: assert property (
        (st.pcm_div == 5'h0 && $changed(st.pcm_int)) |-> ##24 $changed(st.pcm_int))
        else $error("internal PCM half period not 24 cycles");

    chk_addr_zero: assert property ($rose(rst_n) |-> mem_addr == 22'h0 [*4])
        else $error("address not zero after reset");

    chk_ext_oe: assert property (
        (st.boot == dpc_pkg::DPC_BT_BOOT && !boot_internal) |=> !mem_oe_n || remap)
        else $error("output enable not asserted in external boot");

    chk_ext_cs0: assert property (
        ($past(st.boot) == dpc_pkg::DPC_BT_BOOT && !$past(boot_internal) && $past(fetch))
        |-> !esm_cs_n[0])
        else $error("chip select zero missing on fetch");

    chk_cfg_reset: assert property ($rose(rst_n) |-> cfg_rdata == dpc_pkg::CFG_RST)
        else $error("control bits wrong after reset");

    chk_pin_dir: assert property (cfg_wr |=> pdc_oe == $past(cfg_wdata.pdc_out)
        && pfs_oe == $past(cfg_wdata.pfs_out))
        else $error("PCM pin direction not taken");

    chk_freq_sel: assert property (cfg_wr |=> dsp_freq_sel == $past(cfg_wdata.core_freq))
        else $error("core frequency selection not taken");

    chk_settle_drop: assert property (
        (cfg_wr && cfg_wdata.core_freq != cfg_rdata.core_freq) |=> !dsp_pll_settled)
        else $error("settle flag not cleared on new frequency");

    chk_strap_hold: assert property (
        (st.boot == dpc_pkg::DPC_BT_BOOT) |=> $stable(hpi_route) && $stable(cs0_width16))
        else $error("straps changed after capture");

    chk_tic_gate: assert property (!st.strap.tic |=> !tic_req_a)
        else $error("test request without test mode");
endmodule

// ===== sim/tb_dsp_and_pcm_clock_control.sv
// Purpose: Self-checking bench for the core and PCM clock control block.
// Assumes: Inputs change at the falling edge; outputs are sampled there too.
// Notes:   Settle count shortened to 50 cycles to keep the run brief.
`timescale 1ns/1ns
module tb_dsp_and_pcm_clock_control;
    localparam int SETTLE = 50;
    logic                 mclk;
    logic                 rst_n;
    logic                 cfg_wr;
    dpc_pkg::dpc_cfg_s    cfg_wdata;
    dpc_pkg::dpc_cfg_s    cfg_rdata;
    logic                 dsp_pll_settled;
    dpc_pkg::dpc_pins_s   pins;
    dpc_pkg::dpc_freq_e   dsp_freq_sel;
    logic                 dsp_gate_en, dsp_src_xtal, arm_pll_fast, arm_clk_test, clk_out;
    logic                 pdc_o, pdc_oe, pfs_o, pfs_oe;
    logic                 boot_internal, hpi_route, cs0_width16, tic_req_a;
    logic [21:0]          mem_addr_req;
    logic [21:0]          mem_addr;
    logic                 mem_oe_req_n, fetch, remap, mem_oe_n, px_run;
    logic [2:0]           cs_dec_n;
    logic [2:0]           esm_cs_n;
    logic [1:0]           pxcnt;
    int                   miscompares;
    int                   comparisons;

    dpc_clock_ctrl #(.SETTLE_CYCLES(SETTLE)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .dsp_pll_settled(dsp_pll_settled), .pins(pins),
        .dsp_freq_sel(dsp_freq_sel), .dsp_gate_en(dsp_gate_en), .dsp_src_xtal(dsp_src_xtal),
        .arm_pll_fast(arm_pll_fast), .arm_clk_test(arm_clk_test), .clk_out(clk_out),
        .pdc_o(pdc_o), .pdc_oe(pdc_oe), .pfs_o(pfs_o), .pfs_oe(pfs_oe),
        .boot_internal(boot_internal), .hpi_route(hpi_route), .cs0_width16(cs0_width16),
        .tic_req_a(tic_req_a), .mem_addr_req(mem_addr_req), .mem_oe_req_n(mem_oe_req_n),
        .fetch(fetch), .cs_dec_n(cs_dec_n), .remap(remap), .mem_addr(mem_addr),
        .mem_oe_n(mem_oe_n), .esm_cs_n(esm_cs_n)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // External PCM crystal stand-in, period of 8 mclk cycles
    always @(negedge mclk) begin
        pxcnt <= pxcnt + 2'h1;
        if (px_run && pxcnt == 2'h3) begin
            pins.pxtal <= ~pins.pxtal;
        end
    end

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_bits(input string name, input logic [21:0] exp, input logic [21:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic check_cfg(input string name, input dpc_pkg::dpc_cfg_s exp,
                             input dpc_pkg::dpc_cfg_s got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic bound_ok(input int n, input int lim);
        if (n >= lim) begin
            $display("mismatch wait_bound expected %0d seen %0d", lim, n);
            miscompares++;
            conclude();
        end
    endtask

    function automatic dpc_pkg::dpc_pins_s mk_pins(input logic [3:0] ts, input logic [4:0] b);
        dpc_pkg::dpc_pins_s p;
        p = '0;
        p.test_sel = ts;
        {p.boot, p.iface, p.width, p.arm_freq, p.bypass} = b;
        return p;
    endfunction

    task automatic wr_cfg(input dpc_pkg::dpc_cfg_s c);
        @(negedge mclk);
        cfg_wr = 1'b1;
        cfg_wdata = c;
        @(negedge mclk);
        cfg_wr = 1'b0;
        @(negedge mclk);
        check_cfg("cfg_rdata", c, cfg_rdata);
        check_bits("pdc_oe", {21'h0, c.pdc_out}, {21'h0, pdc_oe});
        check_bits("pfs_oe", {21'h0, c.pfs_out}, {21'h0, pfs_oe});
    endtask

    task automatic do_reset(input dpc_pkg::dpc_pins_s p);
        @(negedge mclk);
        rst_n = 1'b0;
        pins = p;
        remap = 1'b0;
        mem_addr_req = 22'h3fffff;
        #1;
        check_cfg("cfg_in_reset", dpc_pkg::CFG_RST, cfg_rdata);
        check_bits("oe_in_reset", 22'h0, {20'h0, pdc_oe, pfs_oe});
        check_bits("gate_in_reset", 22'h1, {21'h0, dsp_gate_en});
        check_bits("addr_in_reset", 22'h0, mem_addr);
        check_bits("oe_n_in_reset", 22'h1, {21'h0, mem_oe_n});
        check_bits("cs_n_in_reset", 22'h7, {19'h0, esm_cs_n});
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        check_bits("addr_after_reset", 22'h0, mem_addr);
        repeat (6) @(negedge mclk);
        check_bits("boot_internal", {21'h0, p.boot}, {21'h0, boot_internal});
        check_bits("hpi_route", {21'h0, p.iface}, {21'h0, hpi_route});
        check_bits("cs0_width16", {21'h0, p.width}, {21'h0, cs0_width16});
        check_bits("arm_pll_fast", {21'h0, p.arm_freq}, {21'h0, arm_pll_fast});
        check_bits("bypass_src", {20'h0, {2{p.bypass}}}, {20'h0, dsp_src_xtal, arm_clk_test});
        check_bits("tic_req_a", {21'h0, p.test_sel == dpc_pkg::TEST_TIC && p.boot},
                   {21'h0, tic_req_a});
    endtask

    task automatic t_mem_ext();
        mem_addr_req = 22'h2a5a5a;
        fetch = 1'b1;
        mem_oe_req_n = 1'b1;
        cs_dec_n = 3'h7;
        repeat (2) @(negedge mclk);
        check_bits("mem_addr", 22'h2a5a5a, mem_addr);
        check_bits("boot_oe_n", 22'h0, {21'h0, mem_oe_n});
        check_bits("boot_cs0_fetch", 22'h0, {21'h0, esm_cs_n[0]});
        fetch = 1'b0;
        repeat (2) @(negedge mclk);
        check_bits("boot_cs0_idle", 22'h1, {21'h0, esm_cs_n[0]});
        remap = 1'b1;
        cs_dec_n = 3'h6;
        repeat (2) @(negedge mclk);
        check_bits("run_cs_n", 22'h6, {19'h0, esm_cs_n});
        check_bits("run_oe_n", 22'h1, {21'h0, mem_oe_n});
    endtask

    task automatic t_mem_int();
        cs_dec_n = 3'h5;
        fetch = 1'b1;
        mem_oe_req_n = 1'b1;
        repeat (2) @(negedge mclk);
        check_bits("int_cs_n", 22'h5, {19'h0, esm_cs_n});
        check_bits("int_oe_n", 22'h1, {21'h0, mem_oe_n});
    endtask

    task automatic t_core_change();
        dpc_pkg::dpc_cfg_s c;
        int n;
        c = dpc_pkg::CFG_RST;
        pins.dsp_src = 1'b1;
        c.core_en = 1'b0;
        wr_cfg(c);
        repeat (6) @(negedge mclk);
        check_bits("gate_held_high_src", 22'h1, {21'h0, dsp_gate_en});
        pins.dsp_src = 1'b0;
        n = 0;
        while (dsp_gate_en !== 1'b0 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        bound_ok(n, 10);
        repeat (10) @(negedge mclk);
        for (int f = 1; f < 5; f++) begin
            c.core_freq = dpc_pkg::dpc_freq_e'(f[1:0]);
            wr_cfg(c);
            check_bits("freq_sel", {20'h0, f[1:0]}, {20'h0, dsp_freq_sel});
            check_bits("settling", 22'h0, {21'h0, dsp_pll_settled});
            n = 0;
            while (dsp_pll_settled !== 1'b1 && n < 200) begin
                @(negedge mclk);
                n++;
            end
            bound_ok(n, 200);
            check_bits("settle_len", 22'h1, {21'h0, n >= SETTLE - 5 && n <= SETTLE + 2});
        end
        c.core_en = 1'b1;
        wr_cfg(c);
        check_bits("gate_running", 22'h1, {21'h0, dsp_gate_en});
    endtask

    task automatic t_clk_out();
        logic s [8];
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            s[i] = clk_out;
        end
        for (int i = 0; i < 6; i++) begin
            check_bits("clk_out", {21'h0, ~s[i]}, {21'h0, s[i + 2]});
        end
    endtask

    task automatic t_pcm_int();
        dpc_pkg::dpc_cfg_s c;
        int n;
        int h;
        logic v;
        c = dpc_pkg::CFG_RST;
        c.pdc_out = 1'b1;
        c.pfs_out = 1'b1;
        wr_cfg(c);
        n = 0;
        v = pdc_o;
        while (pdc_o === v && n < 100) begin
            @(negedge mclk);
            n++;
        end
        bound_ok(n, 100);
        v = pdc_o;
        n = 0;
        while (pdc_o === v && n < 100) begin
            @(negedge mclk);
            n++;
        end
        bound_ok(n, 100);
        check_bits("pcm_half", 22'(dpc_pkg::PCM_INT_HALF), n[21:0]);
        n = 0;
        while (pfs_o !== 1'b0 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        while (pfs_o !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        bound_ok(n, 20000);
        h = 0;
        while (pfs_o === 1'b1 && h < 20000) begin
            @(negedge mclk);
            h++;
        end
        n = h;
        while (pfs_o !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        bound_ok(n, 20000);
        check_bits("fs_width", 22'(2 * dpc_pkg::PCM_INT_HALF), h[21:0]);
        check_bits("frame_len", 22'(192 * 2 * dpc_pkg::PCM_INT_HALF), n[21:0]);
    endtask

    task automatic t_pcm_ext();
        dpc_pkg::dpc_cfg_s c;
        int k [4] = '{3, 4, 8, 16};
        int cnt;
        logic prev;
        px_run = 1'b1;
        c = dpc_pkg::CFG_RST;
        c.pdc_out = 1'b1;
        for (int r = 0; r < 4; r++) begin
            c.pcm_rate = dpc_pkg::dpc_rate_e'(r[1:0]);
            wr_cfg(c);
            repeat (16) @(negedge mclk);
            cnt = 0;
            prev = pdc_o;
            for (int i = 0; i < 512; i++) begin
                @(negedge mclk);
                if (pdc_o === 1'b1 && prev === 1'b0) begin
                    cnt++;
                end
                prev = pdc_o;
            end
            check_bits("ext_rate", 22'h1, {21'h0, cnt >= k[r] * 4 - 1 && cnt <= k[r] * 4 + 1});
        end
        px_run = 1'b0;
    endtask

    // Bypass must gate on the crystal level, not the normal core source
    task automatic t_bypass_gate();
        dpc_pkg::dpc_cfg_s c;
        c = dpc_pkg::CFG_RST;
        c.core_en = 1'b0;
        pins.xtal = 1'b1;
        wr_cfg(c);
        repeat (4) @(negedge mclk);
        check_bits("bypass_gate_held", 22'h1, {21'h0, dsp_gate_en});
        pins.xtal = 1'b0;
        repeat (4) @(negedge mclk);
        check_bits("bypass_gate_off", 22'h0, {21'h0, dsp_gate_en});
    endtask

    initial begin
        miscompares = 0;
        comparisons = 0;
        rst_n = 1'b0;
        cfg_wr = 1'b0;
        cfg_wdata = dpc_pkg::CFG_RST;
        pins = '0;
        pxcnt = 2'h0;
        px_run = 1'b0;
        mem_addr_req = 22'h0;
        mem_oe_req_n = 1'b1;
        fetch = 1'b0;
        remap = 1'b0;
        cs_dec_n = 3'h7;
        do_reset(mk_pins(4'h0, 5'b01010));
        t_mem_ext();
        t_clk_out();
        t_core_change();
        t_pcm_int();
        do_reset(mk_pins(dpc_pkg::TEST_PCM_EXT, 5'b00000));
        t_pcm_ext();
        do_reset(mk_pins(dpc_pkg::TEST_TIC, 5'b10101));
        t_mem_int();
        t_bypass_gate();
        conclude();
    end

    initial begin
        repeat (50000) @(posedge mclk);
        $display("mismatch run_time expected %0d seen %0d", 50000, 50000);
        miscompares++;
        conclude();
    end
endmodule
